// [core/sisu_cfg.svh]
`ifndef SISU_CFG_SVH
`define SISU_CFG_SVH

// Instruction word layout.
`define SISU_INSTR_W      14
`define SISU_DATA_W       8
`define SISU_ADDR_W       7

// Immediate-form subtract: bits 13..9 equal 11110, bit 8 is don't care.
`define SISU_IMM_OPC_HI   13
`define SISU_IMM_OPC_LO   9
`define SISU_IMM_OPC      5'h1e
`define SISU_IMM_HI       7
`define SISU_IMM_LO       0

// Register-form subtract: bits 13..8 equal 000010.
`define SISU_REG_OPC_HI   13
`define SISU_REG_OPC_LO   8
`define SISU_REG_OPC      6'h02
`define SISU_DEST_BIT     7
`define SISU_ADDR_HI      6
`define SISU_ADDR_LO      0

// Destination bit values.
`define SISU_DEST_ACC     1'h0
`define SISU_DEST_FILE    1'h1

// Nibble split for the half borrow.
`define SISU_NIB_HI       3

// Reset values.
`define SISU_ACC_RST      8'h00
`define SISU_DATA_RST     8'h00
`define SISU_ADDR_RST     7'h00

`endif

// [core/sisu_pkg.sv]
`include "sisu_cfg.svh"

package sisu_pkg;

	typedef enum logic [1:0] {
		SISU_OP_NONE,
		SISU_OP_IMM,
		SISU_OP_REG
	} sisu_op_e;

	typedef logic [`SISU_INSTR_W-1:0] sisu_instr_t;
	typedef logic [`SISU_DATA_W-1:0]  sisu_data_t;
	typedef logic [`SISU_ADDR_W-1:0]  sisu_addr_t;

	typedef struct packed {
		logic carry;
		logic half_borrow_not_flag;
		logic zero;
	} sisu_flags_s;

	typedef struct packed {
		logic       en;
		sisu_addr_t addr;
		sisu_data_t data;
	} sisu_wr_s;

endpackage : sisu_pkg

// [core/sisu_core.sv]
// What this block does
// - Immediate form computes immediate minus accumulator.
// - Immediate is instruction low byte, unsigned.
// - Immediate form writes accumulator only.
// - Register form reads addressed file register minus accumulator.
// - Destination bit picks accumulator or file register.
// - Carry set when no borrow occurs.
// - Zero flag set on zero difference.

`include "sisu_cfg.svh"

module sisu_core (
	// Clock and reset.
	input  wire  logic                mclk,
	input  wire  logic                rst,
	// Instruction from the decode stage.
	input  wire  logic                instr_valid,
	input  wire  sisu_pkg::sisu_instr_t instr_word,
	// File register read port.
	output wire  logic [6:0]          file_raddr,
	input  wire  sisu_pkg::sisu_data_t file_rdata,
	// Accumulator load from the rest of the core.
	input  wire  logic                acc_load,
	input  wire  sisu_pkg::sisu_data_t acc_load_data,
	// Results.
	output wire  sisu_pkg::sisu_data_t acc,
	output wire  sisu_pkg::sisu_wr_s  file_wr,
	output wire  sisu_pkg::sisu_flags_s flags,
	output wire  logic                flags_upd,
	output wire  logic                sub_taken
);
	import sisu_pkg::*;

	// Decode.
	wire logic        is_imm;
	wire logic        is_reg;
	wire sisu_op_e    op;
	wire logic        dest_file;
	wire sisu_data_t  imm_val;
	wire sisu_addr_t  f_addr;

	assign is_imm    = instr_valid && (instr_word[`SISU_IMM_OPC_HI:
		`SISU_IMM_OPC_LO] == `SISU_IMM_OPC);
	assign is_reg    = instr_valid && (instr_word[`SISU_REG_OPC_HI:
		`SISU_REG_OPC_LO] == `SISU_REG_OPC);
	assign op        = is_imm ? SISU_OP_IMM :
		(is_reg ? SISU_OP_REG : SISU_OP_NONE);
	assign dest_file = instr_word[`SISU_DEST_BIT];
	assign imm_val   = instr_word[`SISU_IMM_HI:`SISU_IMM_LO];
	assign f_addr    = instr_word[`SISU_ADDR_HI:`SISU_ADDR_LO];
	assign file_raddr = f_addr;

	// Registers.
	sisu_data_t  acc_ff;
	sisu_data_t  nxt_acc;
	sisu_wr_s    wr_ff;
	sisu_wr_s    nxt_wr;
	sisu_flags_s flags_ff;
	sisu_flags_s nxt_flags;
	logic        upd_ff;
	logic        nxt_upd;

	// Subtractor: the minuend is the immediate or the file register.
	wire sisu_data_t minuend;
	wire logic [8:0] diff9;
	wire logic [4:0] diff5;
	wire sisu_data_t diff;
	wire logic       borrow_n;
	wire logic       half_borrow_n;
	wire logic       diff_zero;

	assign minuend = (op == SISU_OP_IMM) ? imm_val : file_rdata;
	assign diff9   = {1'h0, minuend} - {1'h0, acc_ff};
	assign diff    = diff9[7:0];
	assign borrow_n = ~diff9[8];
	assign diff5   = {1'h0, minuend[`SISU_NIB_HI:0]}
		- {1'h0, acc_ff[`SISU_NIB_HI:0]};
	assign half_borrow_n = ~diff5[4];
	assign diff_zero = (diff == `SISU_DATA_RST);

	// Next state.
	always_comb begin
		nxt_acc   = acc_ff;
		nxt_wr    = '0;
		nxt_flags = flags_ff;
		nxt_upd   = 1'h0;
		case (op)
			SISU_OP_IMM: begin
				nxt_acc = diff;
				nxt_upd = 1'h1;
			end
			SISU_OP_REG: begin
				nxt_upd = 1'h1;
				if (dest_file == `SISU_DEST_FILE) begin
					nxt_wr.en   = 1'h1;
					nxt_wr.addr = f_addr;
					nxt_wr.data = diff;
				end else begin
					nxt_acc = diff;
				end
			end
			default: begin
				if (acc_load) begin
					nxt_acc = acc_load_data;
				end
			end
		endcase
		if (nxt_upd) begin
			nxt_flags.carry                = borrow_n;
			nxt_flags.half_borrow_not_flag = half_borrow_n;
			nxt_flags.zero                 = diff_zero;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_ff   <= `SISU_ACC_RST;
			wr_ff    <= '0;
			flags_ff <= '0;
			upd_ff   <= 1'h0;
		end else begin
			acc_ff   <= nxt_acc;
			wr_ff    <= nxt_wr;
			flags_ff <= nxt_flags;
			upd_ff   <= nxt_upd;
		end
	end

	assign acc       = acc_ff;
	assign file_wr   = wr_ff;
	assign flags     = flags_ff;
	assign flags_upd = upd_ff;
	assign sub_taken = (op != SISU_OP_NONE);

	// Checks.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_imm_issue;
		is_imm;
	endsequence

	sequence s_reg_to_acc;
		is_reg && (dest_file == `SISU_DEST_ACC);
	endsequence

	sequence s_reg_to_file;
		is_reg && (dest_file == `SISU_DEST_FILE);
	endsequence

	sequence s_flags_seen;
		upd_ff ##1 !upd_ff;
	endsequence

	a_imm_difference: assert property (
		s_imm_issue |=> acc_ff ==
			8'($past(instr_word[7:0]) - $past(acc_ff)))
		else $error("Immediate subtract result wrong.");

	a_imm_low_byte: assert property (
		is_imm |-> minuend == instr_word[7:0])
		else $error("Immediate operand not the low byte.");

	a_imm_no_file: assert property (
		s_imm_issue |=> !wr_ff.en && upd_ff)
		else $error("Immediate subtract wrote a file register.");

	a_reg_read_addr: assert property (
		is_reg |-> file_raddr == instr_word[6:0]
			&& minuend == file_rdata)
		else $error("Register subtract read the wrong source.");

	a_dest_acc_path: assert property (
		s_reg_to_acc |=> !wr_ff.en
			&& acc_ff == 8'($past(file_rdata) - $past(acc_ff)))
		else $error("Accumulator destination mishandled.");

	a_dest_file_path: assert property (
		s_reg_to_file |=> wr_ff.en && acc_ff == $past(acc_ff)
			&& wr_ff.addr == $past(f_addr)
			&& wr_ff.data == 8'($past(file_rdata) - $past(acc_ff)))
		else $error("File destination mishandled.");

	a_carry_no_borrow: assert property (
		sub_taken |=> flags_ff.carry == ($past(minuend) >= $past(acc_ff)))
		else $error("Carry flag wrong after subtract.");

	a_zero_flag: assert property (
		sub_taken |=> flags_ff.zero == ($past(minuend) == $past(acc_ff))
			&& (!flags_ff.zero || flags_ff.carry))
		else $error("Zero flag wrong after subtract.");

	a_half_borrow: assert property (
		sub_taken |=> flags_ff.half_borrow_not_flag ==
			($past(minuend[3:0]) >= $past(acc_ff[3:0])))
		else $error("Half borrow flag wrong after subtract.");

	a_flags_hold: assert property (
		!sub_taken |=> $stable(flags_ff) && !upd_ff && !wr_ff.en)
		else $error("Flags or write changed without a subtract.");

	a_upd_pulse: assert property (
		sub_taken ##1 !sub_taken |-> s_flags_seen)
		else $error("Flag update pulse malformed.");

	a_sub_over_load: assert property (
		is_imm && acc_load |=> acc_ff ==
			8'($past(imm_val) - $past(acc_ff)))
		else $error("Accumulator load overrode a subtract.");

	a_file_wr_gate: assert property (
		!(is_reg && dest_file == `SISU_DEST_FILE)
			|=> !wr_ff.en)
		else $error("File write without a file destination.");

	a_acc_idle_hold: assert property (
		!sub_taken && !acc_load |=> acc_ff == $past(acc_ff))
		else $error("Accumulator changed without a cause.");

	a_upd_cause: assert property (
		upd_ff |-> $past(sub_taken))
		else $error("Flag update without a subtract.");

endmodule // sisu_core

// [sim/sisu_core_tb_top.sv]
module sisu_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sisu_pkg::*;

	logic        mclk = 1'h0;
	logic        rst = 1'h1;
	logic        instr_valid = 1'h0;
	logic        acc_load = 1'h0;
	sisu_instr_t instr_word = 14'h0;
	sisu_data_t  file_rdata = 8'h0;
	sisu_data_t  acc_load_data = 8'h0;
	sisu_data_t  acc;
	logic [6:0]  file_raddr;
	sisu_wr_s    file_wr;
	sisu_flags_s flags;
	logic        flags_upd;
	logic        sub_taken;
	int          num_errors = 0;
	int          tests_run = 0;

	always #20 mclk = ~mclk;

	sisu_core u_dut (
		.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
		.instr_word(instr_word), .file_raddr(file_raddr),
		.file_rdata(file_rdata), .acc_load(acc_load),
		.acc_load_data(acc_load_data), .acc(acc), .file_wr(file_wr),
		.flags(flags), .flags_upd(flags_upd), .sub_taken(sub_taken)
	);

	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic logic [10:0] ref_sub(input logic [7:0] m, s);
		return {m - s, m >= s, m[3:0] >= s[3:0], m == s};
	endfunction

	task load(input sisu_data_t v);
		@(negedge mclk);
		acc_load = 1'h1;
		acc_load_data = v;
		@(negedge mclk);
		acc_load = 1'h0;
	endtask

	task issue(input sisu_instr_t w, input sisu_data_t fd);
		@(negedge mclk);
		instr_valid = 1'h1;
		instr_word = w;
		file_rdata = fd;
		#1 chk("taken", 16'h1, sub_taken);
		chk("raddr", w[6:0], file_raddr);
		@(negedge mclk);
		instr_valid = 1'h0;
	endtask

	task imm_case(input sisu_data_t k, w, input logic b8);
		logic [10:0] e;
		e = ref_sub(k, w);
		load(w);
		issue({5'h1e, b8, k}, ~k);
		chk("acc", e[10:3], acc);
		chk("flags", e[2:0], flags);
		chk("upd", 16'h1, flags_upd);
		chk("wr_en", 16'h0, file_wr.en);
	endtask

	task reg_case(input logic d, input sisu_addr_t f, input sisu_data_t fd, w);
		logic [10:0] e;
		e = ref_sub(fd, w);
		load(w);
		issue({6'h02, d, f}, fd);
		chk("acc", d ? w : e[10:3], acc);
		chk("flags", e[2:0], flags);
		chk("wr_en", d, file_wr.en);
		if (d) chk("wr", {f, e[10:3]}, {file_wr.addr, file_wr.data});
		@(negedge mclk);
		chk("pulse", 16'h0, {flags_upd, file_wr.en});
	endtask

	task back_to_back();
		load(8'h05);
		@(negedge mclk);
		instr_valid = 1'h1;
		instr_word = 14'h3c08;
		@(negedge mclk);
		instr_word = 14'h3d01;
		acc_load = 1'h1;
		acc_load_data = 8'h77;
		@(negedge mclk);
		instr_valid = 1'h0;
		acc_load = 1'h0;
		chk("acc", 16'hfe, acc);
		chk("flags", 16'h0, flags);
	endtask

	task other_words();
		sisu_instr_t ws[3];
		sisu_flags_s f0;
		ws[0] = 14'h3a55;
		ws[1] = 14'h0c85;
		ws[2] = 14'h3c02;
		foreach (ws[i]) begin
			load(8'h40);
			f0 = flags;
			@(negedge mclk);
			instr_valid = (i < 2);
			instr_word = ws[i];
			#1 chk("taken", 16'h0, sub_taken);
			@(negedge mclk);
			instr_valid = 1'h0;
			chk("acc", 16'h40, acc);
			chk("flags", f0, flags);
			chk("pulse", 16'h0, {flags_upd, file_wr.en});
		end
	endtask

	task mid_reset();
		load(8'h5a);
		@(negedge mclk);
		rst = 1'h1;
		@(negedge mclk);
		rst = 1'h0;
		chk("mid_rst", 16'h0, {acc, flags, flags_upd, file_wr.en});
	endtask

	task conclude();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge mclk);
		rst = 1'h0;
		chk("rst", 16'h0, {acc, flags, flags_upd, file_wr.en});
		imm_case(8'h02, 8'h01, 1'h0);
		imm_case(8'h02, 8'h02, 1'h1);
		imm_case(8'h02, 8'h03, 1'h0);
		imm_case(8'hff, 8'h00, 1'h1);
		imm_case(8'h10, 8'h01, 1'h0);
		imm_case(8'h00, 8'hff, 1'h0);
		reg_case(1'h1, 7'h05, 8'h03, 8'h02);
		reg_case(1'h1, 7'h7f, 8'h02, 8'h02);
		reg_case(1'h0, 7'h7f, 8'h01, 8'h02);
		reg_case(1'h0, 7'h00, 8'h80, 8'h0f);
		back_to_back();
		mid_reset();
		other_words();
		conclude();
	end

	initial begin
		repeat (400) @(posedge mclk);
		num_errors++;
		conclude();
	end
endmodule // sisu_core_tb_top
